// File: rtl/els_handler_consts.vh
/*
 extended link service handler constants: frame identification, command
 codes, payload words and reply reason codes.
 assumes the including file uses them with sized comparisons.
*/
`ifndef ELS_HANDLER_CONSTS_VH
`define ELS_HANDLER_CONSTS_VH
// frame identification
`define RCTL_ROUTE_ELS 4'h2
`define TYPE_ELS 8'h01
// command codes, bits 31-24 of the first payload word
`define CMD_POS 24
`define CMD_REJECT 8'h01
`define CMD_ACCEPT 8'h02
`define CMD_PORT_LOGIN 8'h03
`define CMD_FABRIC_LOGIN 8'h04
`define CMD_LOGOUT 8'h05
`define CMD_ABORT_XCHG 8'h06
`define CMD_SEQ_INIT_REQ 8'h0A
`define CMD_STREAMING 8'h0B
`define CMD_CREDIT_EST 8'h0C
`define CMD_CREDIT_ADV 8'h0D
`define CMD_LOOP_TEST 8'h11
`define CMD_REINSTATE_RQ 8'h12
// recovery qualifier status byte
`define RQ_NOT_NEEDED 8'h00
`define RQ_NEEDED 8'h80
// shared exchange identifier
`define XID_SHARED 16'hFFFF
// recovery qualifier seq_cnt range
`define RQ_LOW_CNT 16'h0000
`define RQ_HIGH_CNT 16'hFFFF
// reply reason codes (coded locally)
`define RSN_UNSUPPORTED 8'h0B
`define RSN_BAD_PAYLOAD 8'h03
`define RSN_IN_PROGRESS 8'h19
`define RSN_RQ_REQUIRED 8'h1F
`define RSN_NOT_PARTY 8'h09
// payload words of abort request
`define ABTX_WORDS 3'd3
`define ABTX_ASSOC_WORDS 4'd8
`endif

// File: rtl/els_handler.v
/*
 extended link service handler: decodes received link service requests word
 by word, validates abort exchange and login requests, and produces a reply
 command with reason, an exchange abort pulse and recovery qualifier state.
 assumes frame header fields are presented with frm_start, before the first payload word, and
 that payload words arrive synchronous to clk, one per cycle when valid.
*/
// Function
// - command code sits in bits 31-24
// - only first frame carries command word
// - decode reject, accept, requests, reserved codes
// - no initiative transfer aborts exchange, no reply
// - credit estimate and test get no reply
// - support both logins, logout, reinstate qualifier
// - port login answered accept or reject only
// - request and reply share one exchange
// - ox_id from originator, rx_id assigned here
// - payload lengths are whole words
// - colliding abort/initiative rejected when we originate
// - abort accepted only from exchange parties
// - terminated id pair must match request
// - classes 2/3 set qualifier zero to FFFF
// - status 00 or 80; reject if required
// - abort terminates all sequences, accept confirms
// - abort payload words and optional association header
// - abort accept payload is single word
// - routing 0010 and type 01 mark frame
`include "els_handler_consts.vh"
`default_nettype none
module els_handler (
   input wire clk,
   input wire rst_n,
   input wire clk_en,
   input wire frm_start,
   input wire [3:0] frm_route,
   input wire [7:0] frm_type,
   input wire frm_first_seq_frame,
   input wire [15:0] frm_ox_id,
   input wire [23:0] frm_s_id,
   input wire [1:0] frm_class,
   input wire frm_only_xchg,
   input wire word_valid,
   input wire [31:0] word_data,
   input wire frm_end,
   input wire frm_bytes_ok,
   input wire frm_seq_end,
   input wire frm_seq_init,
   input wire frm_login_bad,
   input wire assoc_hdr_req,
   input wire tgt_open,
   input wire tgt_we_orig,
   input wire tgt_own_abtx,
   input wire [15:0] tgt_ox_id,
   input wire [15:0] tgt_rx_id,
   input wire [23:0] tgt_orig_sid,
   input wire [23:0] tgt_resp_sid,
   input wire tgt_lost_frames,
   input wire [15:0] local_rx_id,
   output reg reply_valid,
   output reg [31:0] reply_word,
   output reg [7:0] reply_reason,
   output reg [15:0] reply_ox_id,
   output reg [15:0] reply_rx_id,
   output reg xchg_abort,
   output reg tgt_terminate,
   output reg rq_valid,
   output reg [15:0] rq_low,
   output reg [15:0] rq_high,
   output reg [7:0] cmd_seen
);
   // ************************************************************
   // states
   // ************************************************************
   localparam [2:0] ST_IDLE = 3'd0;
   localparam [2:0] ST_BODY = 3'd1;
   localparam [2:0] ST_SKIP = 3'd2;
   localparam [2:0] ST_WAIT = 3'd3;
   localparam [2:0] ST_DECIDE = 3'd4;

   reg [2:0] state_q;
   reg [7:0] cmd_q;
   reg [3:0] word_cnt_q;
   reg [7:0] rq_stat_q;
   reg [23:0] ab_sid_q;
   reg [15:0] ab_ox_q;
   reg [15:0] ab_rx_q;
   reg fmt_bad_q;
   reg si_q;
   reg [15:0] ox_q;
   reg [23:0] sid_q;
   reg [1:0] class_q;
   reg only_q;

   // ************************************************************
   // frame qualification
   // ************************************************************
   wire is_els = (frm_route == `RCTL_ROUTE_ELS) && (frm_type == `TYPE_ELS);
   wire [7:0] in_cmd = word_data[31:`CMD_POS];
   wire code_ok = (in_cmd >= `CMD_PORT_LOGIN) && (in_cmd <= `CMD_REINSTATE_RQ);
   wire is_reply = (in_cmd == `CMD_REJECT) || (in_cmd == `CMD_ACCEPT);
   wire [3:0] need_words = assoc_hdr_req ? ({1'b0, `ABTX_WORDS} + `ABTX_ASSOC_WORDS)
      : {1'b0, `ABTX_WORDS};

   // ************************************************************
   // reply sequence detection
   // ************************************************************
   // a received reply belongs to a request that this port sent, so it must
   // never reach the decision stage: there it would look like a reserved
   // request code and be answered with a reject. on the first payload word
   // the live code decides; on later words the captured code does.
   // the state register cannot be used for this, because a code word that
   // also ends the frame would have its skip overwritten at the frame end.
   wire reply_seq = (word_valid && (word_cnt_q == 4'h0)) ? is_reply
      : ((cmd_q == `CMD_REJECT) || (cmd_q == `CMD_ACCEPT));

   // ************************************************************
   // decision for a complete request
   // ************************************************************
   reg [1:0] act;
   reg [7:0] rsn;
   reg pair_ok;
   reg party_ok;
   always @*
   begin
      act = 2'd0; // 0 none, 1 accept, 2 reject, 3 abort exchange
      rsn = 8'h00;
      pair_ok = tgt_open && (ab_ox_q == tgt_ox_id) && (ab_rx_q == tgt_rx_id)
         && (ab_sid_q == tgt_orig_sid);
      party_ok = (sid_q == tgt_orig_sid) || (sid_q == tgt_resp_sid);
      if (!si_q)
      begin
         act = 2'd3;
      end
      else if (fmt_bad_q)
      begin
         act = 2'd2;
         rsn = `RSN_BAD_PAYLOAD;
      end
      else
      begin
         case (cmd_q)
            `CMD_CREDIT_EST, `CMD_LOOP_TEST:
               act = 2'd0;
            `CMD_PORT_LOGIN:
            begin
               act = frm_login_bad ? 2'd2 : 2'd1;
               rsn = frm_login_bad ? `RSN_BAD_PAYLOAD : 8'h00;
            end
            `CMD_FABRIC_LOGIN, `CMD_LOGOUT, `CMD_REINSTATE_RQ:
               act = 2'd1;
            `CMD_SEQ_INIT_REQ:
            begin
               act = (tgt_own_abtx && tgt_we_orig) ? 2'd2 : 2'd1;
               rsn = (tgt_own_abtx && tgt_we_orig) ? `RSN_IN_PROGRESS : 8'h00;
            end
            `CMD_ABORT_XCHG:
            begin
               act = 2'd2;
               if (!party_ok || !pair_ok)
                  rsn = `RSN_NOT_PARTY;
               else if (tgt_own_abtx && tgt_we_orig)
                  rsn = `RSN_IN_PROGRESS;
               else if ((rq_stat_q == `RQ_NOT_NEEDED) && tgt_lost_frames
                  && (class_q != 2'd1))
                  rsn = `RSN_RQ_REQUIRED;
               else if ((rq_stat_q != `RQ_NOT_NEEDED) && (rq_stat_q != `RQ_NEEDED))
                  rsn = `RSN_BAD_PAYLOAD;
               else
                  act = 2'd1;
            end
            default:
            begin
               act = 2'd2;
               rsn = `RSN_UNSUPPORTED;
            end
         endcase
      end
   end

   // ************************************************************
   // sequence capture and reply generation
   // ************************************************************
   // the reset branch loads constants only; while clk_en is low every
   // register, outputs included, keeps its value, so a pulse that was
   // raised in the last enabled cycle stays up until the next one.
   // a hazard for users: frame strobes presented while clk_en is low are
   // lost, so the frame source must be gated by the same enable.
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_q <= ST_IDLE;
         cmd_q <= 8'h00;
         word_cnt_q <= 4'h0;
         rq_stat_q <= 8'h00;
         ab_sid_q <= 24'h000000;
         ab_ox_q <= 16'h0000;
         ab_rx_q <= 16'h0000;
         fmt_bad_q <= 1'b0;
         si_q <= 1'b0;
         ox_q <= 16'h0000;
         sid_q <= 24'h000000;
         class_q <= 2'h0;
         only_q <= 1'b0;
         reply_valid <= 1'b0;
         reply_word <= 32'h00000000;
         reply_reason <= 8'h00;
         reply_ox_id <= 16'h0000;
         reply_rx_id <= 16'h0000;
         xchg_abort <= 1'b0;
         tgt_terminate <= 1'b0;
         rq_valid <= 1'b0;
         rq_low <= 16'h0000;
         rq_high <= 16'h0000;
         cmd_seen <= 8'h00;
      end
      else if (clk_en)
      begin
         reply_valid <= 1'b0;
         xchg_abort <= 1'b0;
         tgt_terminate <= 1'b0;
         case (state_q)
            ST_IDLE:
            begin
               // a new sequence starts with its first frame only
               if (frm_start && is_els && frm_first_seq_frame)
               begin
                  ox_q <= frm_ox_id;
                  sid_q <= frm_s_id;
                  class_q <= frm_class;
                  only_q <= frm_only_xchg;
                  fmt_bad_q <= 1'b0;
                  word_cnt_q <= 4'h0;
                  state_q <= ST_BODY;
               end
            end
            ST_BODY:
            begin
               if (word_valid)
               begin
                  if (word_cnt_q == 4'h0)
                  begin
                     cmd_q <= in_cmd;
                     cmd_seen <= in_cmd;
                     if (is_reply || !code_ok)
                        cmd_q <= is_reply ? in_cmd : 8'hFF;
                     state_q <= is_reply ? ST_SKIP : ST_BODY;
                  end
                  else if (cmd_q == `CMD_ABORT_XCHG)
                  begin
                     // abort payload: status and s_id, then ox_id and rx_id
                     if (word_cnt_q == 4'h1)
                     begin
                        rq_stat_q <= word_data[31:24];
                        ab_sid_q <= word_data[23:0];
                     end
                     if (word_cnt_q == 4'h2)
                     begin
                        ab_ox_q <= word_data[31:16];
                        ab_rx_q <= word_data[15:0];
                     end
                  end
                  if (word_cnt_q != 4'hF)
                     word_cnt_q <= word_cnt_q + 4'h1;
               end
               if (frm_end)
               begin
                  if (!frm_bytes_ok)
                     fmt_bad_q <= 1'b1;
                  // end of sequence: requests go on to a decision, replies
                  // are dropped; a frame that is not the last one waits for
                  // the continuation frame, or skips it for a reply
                  if (frm_seq_end)
                  begin
                     si_q <= frm_seq_init;
                     state_q <= reply_seq ? ST_IDLE : ST_DECIDE;
                  end
                  else
                     state_q <= reply_seq ? ST_SKIP : ST_WAIT;
               end
            end
            ST_WAIT:
            begin
               // later frames continue the payload, no command word
               if (frm_start && is_els)
                  state_q <= ST_BODY;
            end
            ST_SKIP:
            begin
               // replies are for the requester side, dropped here
               if (frm_end && frm_seq_end)
                  state_q <= ST_IDLE;
            end
            // decision cycle: the combinational verdict is turned into one
            // registered reply, or an exchange abort pulse, never both.
            // the short abort check comes first, since a missing id word
            // would leave the captured pair of an earlier request in place.
            // the id fields are refreshed on every decision, so they stand
            // with the pulse and hold until the next decision.
            ST_DECIDE:
            begin
               if ((cmd_q == `CMD_ABORT_XCHG) && (word_cnt_q < need_words) && si_q)
               begin
                  reply_valid <= 1'b1;
                  reply_word <= {`CMD_REJECT, 24'h000000};
                  reply_reason <= `RSN_BAD_PAYLOAD;
               end
               else if (act == 2'd3)
                  xchg_abort <= 1'b1;
               else if (act != 2'd0)
               begin
                  reply_valid <= 1'b1;
                  reply_word <= {(act == 2'd1) ? `CMD_ACCEPT : `CMD_REJECT, 24'h000000};
                  reply_reason <= rsn;
                  if ((act == 2'd1) && (cmd_q == `CMD_ABORT_XCHG))
                  begin
                     tgt_terminate <= 1'b1;
                     if (tgt_lost_frames && (class_q != 2'd1))
                     begin
                        rq_valid <= 1'b1;
                        rq_low <= `RQ_LOW_CNT;
                        rq_high <= `RQ_HIGH_CNT;
                     end
                  end
                  if ((act == 2'd1) && (cmd_q == `CMD_REINSTATE_RQ))
                     rq_valid <= 1'b0;
               end
               reply_ox_id <= ox_q;
               reply_rx_id <= only_q ? `XID_SHARED : local_rx_id;
               state_q <= ST_IDLE;
            end
            default:
               state_q <= ST_IDLE;
         endcase
      end
   end
endmodule // els_handler
`default_nettype wire

// File: dv/els_peer.sv
/* peer port model: sends single-frame link service request sequences.
   assumes the handler samples its frame inputs on the rising clock edge. */
`default_nettype none
module els_peer (
   input wire clk,
   output logic frm_start,
   output logic [3:0] frm_route,
   output logic [7:0] frm_type,
   output logic frm_first_seq_frame,
   output logic [15:0] frm_ox_id,
   output logic [23:0] frm_s_id,
   output logic [1:0] frm_class,
   output logic frm_only_xchg,
   output logic word_valid,
   output logic [31:0] word_data,
   output logic frm_end,
   output logic frm_bytes_ok,
   output logic frm_seq_end,
   output logic frm_seq_init
);
   timeunit 1ns;
   timeprecision 1ps;
   // idle levels; class 3, whole-word payloads only
   initial
   begin
      {frm_start, word_valid, frm_end, frm_seq_end, frm_seq_init, frm_only_xchg} = '0;
      frm_route = 4'h2;
      frm_type = 8'h01;
      frm_first_seq_frame = 1'b1;
      frm_ox_id = 16'h0123;
      frm_s_id = 24'h0A0B0C;
      frm_class = 2'h3;
      frm_bytes_ok = 1'b1;
      word_data = 32'h0;
   end
   // header, then code word and payload words, one frame per sequence
   task automatic send(input logic [3:0] r, input logic [31:0] w0, input logic [31:0] w1,
      input logic [31:0] w2, input int n, input logic init);
      logic [31:0] w [3];
      w = '{w0, w1, w2};
      @(posedge clk) #1;
      frm_start = 1'b1;
      frm_route = r;
      @(posedge clk) #1;
      frm_start = 1'b0;
      for (int i = 0; i <= n; i++)
      begin
         word_valid = 1'b1;
         word_data = w[i];
         frm_end = (i == n);
         frm_seq_end = (i == n);
         frm_seq_init = init && (i == n);
         @(posedge clk) #1;
      end
      {word_valid, frm_end, frm_seq_end, frm_seq_init} = '0;
      word_data = ~word_data;
   endtask
endmodule // els_peer
`default_nettype wire

// File: dv/els_handler_chk.sv
/* checker on the handler ports.
   assumes exchange lookup levels stay steady during a sequence. */
`default_nettype none
module els_handler_chk (
   input wire clk,
   input wire rst_n,
   input wire frm_start,
   input wire [3:0] frm_route,
   input wire [7:0] frm_type,
   input wire frm_end,
   input wire frm_seq_end,
   input wire frm_seq_init,
   input wire tgt_we_orig,
   input wire tgt_own_abtx,
   input wire reply_valid,
   input wire [31:0] reply_word,
   input wire [7:0] reply_reason,
   input wire xchg_abort,
   input wire tgt_terminate,
   input wire rq_valid,
   input wire [15:0] rq_low,
   input wire [15:0] rq_high,
   input wire [7:0] cmd_seen
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   logic els_q;
   // remembers whether the current frame is a link service frame
   always_ff @(posedge clk or negedge rst_n)
      if (!rst_n)
         els_q <= 1'b0;
      else if (frm_start)
         els_q <= frm_route == 4'h2 && frm_type == 8'h01;
   reply_fmt_a: assert property (reply_valid |-> reply_word[23:0] == 24'h0 &&
      reply_word[31:24] inside {8'h01, 8'h02}) else $error("reply word malformed");
   reply_cause_a: assert property (reply_valid |-> $past(frm_end, 2) && $past(els_q, 2))
      else $error("reply without link service frame");
   no_init_a: assert property (els_q && frm_end && frm_seq_end && !frm_seq_init |->
      ##2 xchg_abort and (!reply_valid) [*4]) else $error("missing exchange abort");
   no_reply_a: assert property (reply_valid |-> !(cmd_seen inside {8'h01, 8'h02, 8'h0C, 8'h11}))
      else $error("reply to silent command");
   rsv_rej_a: assert property (reply_valid && (cmd_seen == 8'h00 || cmd_seen > 8'h12) |->
      reply_word == 32'h01000000 && reply_reason == 8'h0B) else $error("reserved not rejected");
   plogi_rej_a: assert property (reply_valid && cmd_seen == 8'h03 |-> reply_reason != 8'h0B)
      else $error("login rejected as unsupported");
   clash_rej_a: assert property (reply_valid && cmd_seen == 8'h06 && tgt_we_orig && tgt_own_abtx |->
      reply_word == 32'h01000000 && reply_reason == 8'h19) else $error("collision not rejected");
   abort_conf_a: assert property (reply_valid && cmd_seen == 8'h06 && reply_word[31:24] == 8'h02 |->
      tgt_terminate || $past(tgt_terminate) || $past(tgt_terminate, 2)) else $error("accept without terminate");
   rq_range_a: assert property (rq_valid |-> rq_low == 16'h0 && rq_high == 16'hFFFF)
      else $error("qualifier range wrong");
endmodule // els_handler_chk
bind els_handler els_handler_chk els_handler_chk_i (.*);
`default_nettype wire

// File: dv/test_els_handler.sv
/* testbench for the link service handler.
   assumes the peer model drives all frame inputs except frm_login_bad. */
`default_nettype none
module test_extended_link_service_handler;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [31:0] ACC = 32'h02000000, RJT = 32'h01000000, XID = 32'h01230042;
   logic clk = 0, rst_n = 0, clk_en = 1, frm_login_bad = 0, assoc_hdr_req = 0;
   logic tgt_open = 1, tgt_we_orig = 0, tgt_own_abtx = 0, tgt_lost_frames = 0;
   logic [15:0] tgt_ox_id = 16'h0123, tgt_rx_id = 16'h0042, local_rx_id = 16'h0042;
   logic [23:0] tgt_orig_sid = 24'h0A0B0C, tgt_resp_sid = 24'h0D0E0F;
   wire frm_start, frm_first_seq_frame, frm_only_xchg, word_valid, frm_end, frm_bytes_ok;
   wire frm_seq_end, frm_seq_init, reply_valid, xchg_abort, tgt_terminate, rq_valid;
   wire [3:0] frm_route;
   wire [7:0] frm_type, cmd_seen, reply_reason;
   wire [15:0] frm_ox_id, reply_ox_id, reply_rx_id, rq_low, rq_high;
   wire [23:0] frm_s_id;
   wire [1:0] frm_class;
   wire [31:0] word_data, reply_word;
   int fail_count = 0, checks_done = 0, cyc = 0;
   logic rv, ab, tt;
   logic [31:0] rw;
   logic [7:0] rr;
   els_handler els_handler_i (.*);
   els_peer els_peer_i (.*);
   always #4 clk = ~clk;
   // hang guard
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 4000)
      begin
         fail_count++;
         results();
      end
   end
   task automatic results;
      $display("checks %0d errors %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input logic ok, input string m);
      checks_done++;
      if (ok !== 1'b1)
      begin
         fail_count++;
         $display("Error %0t %s", $time, m);
      end
   endtask
   // one request sequence, then watch the reply window
   task automatic run(input logic [3:0] r, input logic [31:0] w0, input logic [31:0] w1, input int n,
      input logic init);
      {rv, ab, tt} = '0;
      els_peer_i.send(r, w0, w1, XID, n, init);
      repeat (5)
      begin
         @(posedge clk) #1;
         if (reply_valid === 1'b1)
            {rv, rw, rr} = {1'b1, reply_word, reply_reason};
         ab |= xchg_abort === 1'b1;
         tt |= tgt_terminate === 1'b1;
      end
   endtask
   task automatic exp(input logic e, input logic [31:0] w, input logic [7:0] r, input string m);
      chk(rv === e && (!e || rw === w && (r === 8'hFF || rr === r) && reply_ox_id === 16'h0123 &&
         reply_rx_id === local_rx_id), m);
   endtask
   task automatic t_login;
      logic [7:0] c [3] = '{8'h03, 8'h04, 8'h05};
      foreach (c[i])
      begin
         run(4'h2, {c[i], 24'h0}, 0, 0, 1);
         exp(1, ACC, 8'hFF, "login accept");
      end
      frm_login_bad = 1;
      run(4'h2, 32'h03000000, 0, 0, 1);
      exp(1, RJT, 8'hFF, "bad login");
      frm_login_bad = 0;
      run(4'h2, 32'h03000000, 0, 0, 0);
      chk(ab && !rv, "no initiative");
      run(4'h3, 32'h03000000, 0, 0, 1);
      exp(0, 0, 0, "foreign frame");
   endtask
   task automatic t_codes;
      logic [7:0] c [7] = '{8'h00, 8'h13, 8'hFF, 8'h01, 8'h02, 8'h0C, 8'h11};
      foreach (c[i])
      begin
         run(4'h2, {c[i], 24'h0}, 0, 0, 1);
         exp(i < 3, RJT, 8'h0B, "code decode");
      end
   endtask
   task automatic t_abort;
      tgt_lost_frames = 1;
      run(4'h2, 32'h06000000, 32'h800A0B0C, 2, 1);
      exp(1, ACC, 8'hFF, "abort accept");
      chk(tt && rq_valid && rq_low === 16'h0 && rq_high === 16'hFFFF, "qualifier");
      run(4'h2, 32'h12000000, 0, 0, 1);
      chk(rv && rw === ACC && rq_valid === 1'b0, "reinstate");
      run(4'h2, 32'h06000000, 32'h000A0B0C, 2, 1);
      exp(1, RJT, 8'h1F, "qualifier needed");
      tgt_lost_frames = 0;
      run(4'h2, 32'h06000000, 32'h000A0B0C, 2, 1);
      exp(1, ACC, 8'hFF, "qualifier not needed");
      run(4'h2, 32'h06000000, 32'h800A0B0C, 1, 1);
      exp(1, RJT, 8'h03, "short abort");
      tgt_rx_id = 16'h0099;
      run(4'h2, 32'h06000000, 32'h800A0B0C, 2, 1);
      chk(rv && rw === RJT && !tt, "id mismatch");
      tgt_rx_id = 16'h0042;
      tgt_orig_sid = 24'h111111;
      run(4'h2, 32'h06000000, 32'h80111111, 2, 1);
      exp(1, RJT, 8'h09, "not a party");
      tgt_orig_sid = 24'h0A0B0C;
      {tgt_we_orig, tgt_own_abtx} = 2'b11;
      run(4'h2, 32'h06000000, 32'h800A0B0C, 2, 1);
      exp(1, RJT, 8'h19, "collision originator");
      tgt_we_orig = 0;
      run(4'h2, 32'h06000000, 32'h800A0B0C, 2, 1);
      exp(1, ACC, 8'hFF, "collision responder");
   endtask
   initial
   begin
      repeat (12) @(posedge clk);
      #1 rst_n = 1;
      t_login();
      t_codes();
      t_abort();
      results();
   end
endmodule // test_extended_link_service_handler
`default_nettype wire
